// File: hdl/rac_pkg.sv
// Constants and types shared by the repeater activity and collision logic
//
// Overview of operation
// RULE1: Outside a collision the repeater is active while a port receives or while buffered data is still being repeated.
// RULE2: While jamming, the repeater is active only while one or more network ports receive.
// RULE3: The activity request toward the expansion link is high exactly while the repeater is active.
// RULE4: Two or more ports receiving at once put the repeater into the collision state.
// RULE5: Any port receiving while the repeater drives repeated data onto it puts the repeater into the collision state.
// RULE6: An active AUI collision indication puts the repeater into the collision state.
// RULE7: In the collision state the repeater sends a jam of alternating ones and zeros on every port.
// RULE8: A port with excessive collisions is isolated and is reconnected after a run of collision-free activity.
// RULE9: A port that sees a collision without being a colliding party is flagged as in receive collision.
// RULE10: The AUI port is in transmit collision when its collision indication is active while it transmits.
// RULE11: A twisted-pair port is in transmit collision when it receives while it transmits; the code flags the lone receiver in a jam as receive collision.
// RULE12: Only the eight twisted-pair ports and the AUI port take part in activity, collision and partitioning.
package rac_pkg;

  // ---------------------------------------------------------------------------
  // Port map
  // ---------------------------------------------------------------------------
  localparam int unsigned TP_PORTS = 8;
  localparam int unsigned NPORT    = TP_PORTS + 1;
  localparam int unsigned AUI_IDX  = TP_PORTS;
  localparam logic [NPORT-1:0] PORT_NONE = 9'h000;
  localparam logic [NPORT-1:0] PORT_ALL  = 9'h1FF;

  // ---------------------------------------------------------------------------
  // Partition defaults and data path sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned CCNT_W         = 6;
  localparam int unsigned GCNT_W         = 10;
  localparam int unsigned PART_LIMIT_DEF = 32;
  localparam int unsigned RECON_CYC_DEF  = 512;
  localparam int unsigned DATA_W_DEF     = 1;
  localparam int unsigned BUF_DEPTH      = 2;

  // ---------------------------------------------------------------------------
  // Repeater state, Gray coded along idle, repeat, jam
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RAC_IDLE = 2'b00,
    RAC_RPT  = 2'b01,
    RAC_JAM  = 2'b11
  } rac_state_t;

endpackage : rac_pkg

// File: hdl/rac_buf_if.sv
// Handshake bundle between the repeater core and its two-entry buffer
`timescale 1ns/1ps
interface rac_buf_if #(
  parameter int unsigned DATA_W = 1
);
  logic              wr_valid;
  logic              wr_ready;
  logic [DATA_W-1:0] wr_data;
  logic              rd_valid;
  logic              rd_ready;
  logic [DATA_W-1:0] rd_data;
  logic              flush;

  modport user  (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data);
  modport store (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data);
endinterface : rac_buf_if

// File: hdl/rac_buf.sv
// Two-entry data buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
module rac_buf
  import rac_pkg::*;
#(
  parameter int unsigned DATA_W = DATA_W_DEF,
  parameter int unsigned DEPTH  = BUF_DEPTH
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Buffer side of the bundle
  rac_buf_if.store  bif
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0]     wr_ptr;
  logic [PW-1:0]     rd_ptr;
  logic [CW-1:0]     count;
  logic [PW-1:0]     next_wr_ptr;
  logic [PW-1:0]     next_rd_ptr;
  logic [CW-1:0]     next_count;
  logic              next_wr_ready;
  logic              wr_ready_q;
  logic              do_wr;
  logic              do_rd;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  assign bif.rd_valid = (count != '0);
  assign bif.rd_data  = mem[rd_ptr];
  // Ready is registered so the core sees a clean flop-driven stall
  assign bif.wr_ready = wr_ready_q;

  always_comb begin
    do_wr       = bif.wr_valid && wr_ready_q && !bif.flush;
    do_rd       = bif.rd_ready && (count != '0) && !bif.flush;
    next_wr_ptr = do_wr ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = do_rd ? ptr_inc(rd_ptr) : rd_ptr;
    next_count  = count + CW'(do_wr) - CW'(do_rd);
    if (bif.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
    next_wr_ready = (next_count < CW'(DEPTH));
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      wr_ready_q <= 1'b1;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      wr_ready_q <= next_wr_ready;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= bif.wr_data;
    end
  end

endmodule : rac_buf

// File: hdl/rac_top.sv
// Repeater activity, collision, jam and port partition logic
`timescale 1ns/1ps
module rac_top
  import rac_pkg::*;
#(
  parameter int unsigned DATA_W     = DATA_W_DEF,
  parameter int unsigned PART_LIMIT = PART_LIMIT_DEF,
  parameter int unsigned RECON_CYC  = RECON_CYC_DEF
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // Network port receive side
  input  wire logic [NPORT-1:0]  rx_carrier_i,
  input  wire logic [DATA_W-1:0] rx_data_i [NPORT],
  input  wire logic              aui_col_i,
  output logic                   rx_ready_o,
  // Network port transmit side
  input  wire logic              tx_ready_i,
  output logic [NPORT-1:0]       tx_en_o,
  output logic [DATA_W-1:0]      tx_data_o,
  // Expansion link
  output logic                   act_req_o,
  output logic                   col_o,
  // Per-port status
  output logic [NPORT-1:0]       tx_col_o,
  output logic [NPORT-1:0]       rx_col_o,
  output logic [NPORT-1:0]       part_o
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] pop_cnt(input logic [NPORT-1:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < NPORT; i++) begin
      n = n + 4'(v[i]);
    end
    pop_cnt = n;
  endfunction : pop_cnt

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  rac_state_t         state;
  rac_state_t         next_state;
  logic [NPORT-1:0]   src;
  logic [NPORT-1:0]   next_src;
  logic               next_act_req;
  logic [NPORT-1:0]   next_tx_en;
  logic [DATA_W-1:0]  next_tx_data;
  logic [NPORT-1:0]   next_tx_col;
  logic [NPORT-1:0]   next_rx_col;
  logic [NPORT-1:0]   rx_eff;
  logic               aui_col_eff;
  logic [3:0]         rx_num;
  logic               col_cond;
  logic               one_left;
  logic [DATA_W-1:0]  rx_word;
  logic [CCNT_W-1:0]  ccnt      [NPORT];
  logic [CCNT_W-1:0]  next_ccnt [NPORT];
  logic [GCNT_W-1:0]  gcnt      [NPORT];
  logic [GCNT_W-1:0]  next_gcnt [NPORT];
  logic [NPORT-1:0]   next_part;
  logic               col_entry;

  rac_buf_if #(.DATA_W(DATA_W)) bif ();

  rac_buf #(
    .DATA_W (DATA_W),
    .DEPTH  (BUF_DEPTH)
  ) u_buf (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .bif       (bif)
  );

  // A full buffer cannot stall the wire, so the stall is exported upstream
  assign rx_ready_o = bif.wr_ready;

  // ---------------------------------------------------------------------------
  // Port qualification
  // ---------------------------------------------------------------------------
  // Partitioned ports are ignored; expansion and management never enter here
  assign rx_eff      = rx_carrier_i & ~part_o;           // [RULE12] [RULE8]
  assign aui_col_eff = aui_col_i & ~part_o[AUI_IDX];     // [RULE12]

  // ---------------------------------------------------------------------------
  // Repeater state, activity and transmit path
  // ---------------------------------------------------------------------------
  always_comb begin
    rx_num   = pop_cnt(rx_eff);
    col_cond = (rx_num >= 4'h2)                          // [RULE4]
               || (|(rx_eff & tx_en_o))                  // [RULE5]
               || aui_col_eff;                           // [RULE6]
    one_left = (state == RAC_JAM) && (rx_num == 4'h1);
    rx_word  = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (rx_eff[i]) begin
        rx_word = rx_word | rx_data_i[i];
      end
    end
    next_state = state;
    next_src   = src;
    unique case (state)
      RAC_IDLE: begin
        if (col_cond) begin
          next_state = RAC_JAM;
        end else if (rx_num == 4'h1) begin
          next_state = RAC_RPT;
          next_src   = rx_eff;
        end
      end
      RAC_RPT: begin
        if (col_cond) begin
          next_state = RAC_JAM;
        end else if (!(|rx_eff) && !bif.rd_valid) begin
          next_state = RAC_IDLE;
        end
      end
      RAC_JAM: begin
        // Jam lasts until every unpartitioned port is quiet and the AUI indication drops
        if (!(|rx_eff) && !aui_col_eff) begin
          next_state = RAC_IDLE;
        end
      end
      default: begin
        next_state = RAC_IDLE;
      end
    endcase

    bif.flush    = (next_state == RAC_JAM);
    bif.wr_valid = (next_state == RAC_RPT) && (|rx_eff);
    bif.wr_data  = rx_word;
    bif.rd_ready = (state == RAC_RPT) && tx_ready_i;

    // Draining a finished reception still counts as active
    next_act_req = (next_state == RAC_RPT)               // [RULE1]
                   || ((next_state == RAC_JAM) && (|rx_eff)); // [RULE2] [RULE3]

    next_tx_en   = PORT_NONE;
    next_tx_data = tx_data_o;
    if (next_state == RAC_JAM) begin
      next_tx_en   = PORT_ALL;                           // [RULE7]
      next_tx_data = ~tx_data_o;                         // [RULE7]
    end else if (next_state == RAC_RPT) begin
      next_tx_en = ~next_src;
      if (bif.rd_valid && tx_ready_i) begin
        next_tx_data = bif.rd_data;
      end
    end

    for (int i = 0; i < NPORT; i++) begin
      if (i == AUI_IDX) begin
        next_tx_col[i] = aui_col_eff && tx_en_o[i];      // [RULE10]
        next_rx_col[i] = aui_col_eff && !tx_en_o[i];     // [RULE9]
      end else begin
        next_tx_col[i] = rx_eff[i] && tx_en_o[i] && !one_left; // [RULE11]
        next_rx_col[i] = rx_eff[i] && one_left;          // [RULE9]
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state     <= RAC_IDLE;
      src       <= PORT_NONE;
      act_req_o <= 1'b0;
      col_o     <= 1'b0;
      tx_en_o   <= PORT_NONE;
      tx_data_o <= '0;
      tx_col_o  <= PORT_NONE;
      rx_col_o  <= PORT_NONE;
    end else begin
      state     <= next_state;
      src       <= next_src;
      act_req_o <= next_act_req;
      col_o     <= (next_state == RAC_JAM);
      tx_en_o   <= next_tx_en;
      tx_data_o <= next_tx_data;
      tx_col_o  <= next_tx_col;
      rx_col_o  <= next_rx_col;
    end
  end

  // ---------------------------------------------------------------------------
  // Partitioning
  // ---------------------------------------------------------------------------
  // Collisions are counted once per collision event, not per cycle
  always_comb begin
    col_entry = (state != RAC_JAM) && (next_state == RAC_JAM);
    for (int i = 0; i < NPORT; i++) begin
      logic involved;
      logic clean;
      involved = (i == AUI_IDX) ? (rx_eff[i] || aui_col_eff) : rx_eff[i];
      // Clean means the raw port is active alone and no jam is in progress
      clean    = rx_carrier_i[i] && !(|(rx_eff & ~(PORT_NONE | (9'h001 << i))))
                 && (state != RAC_JAM) && !col_cond;
      next_ccnt[i] = ccnt[i];
      next_gcnt[i] = clean ? gcnt[i] + GCNT_W'(1) : '0;
      next_part[i] = part_o[i];
      if (col_entry && involved && (ccnt[i] != CCNT_W'(PART_LIMIT))) begin
        next_ccnt[i] = ccnt[i] + CCNT_W'(1);
      end
      if (next_ccnt[i] == CCNT_W'(PART_LIMIT)) begin
        next_part[i] = 1'b1;                             // [RULE8]
      end
      if (clean && (gcnt[i] == GCNT_W'(RECON_CYC - 1))) begin
        next_part[i] = 1'b0;                             // [RULE8]
        next_ccnt[i] = '0;
        next_gcnt[i] = '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      part_o <= PORT_NONE;
      for (int i = 0; i < NPORT; i++) begin
        ccnt[i] <= '0;
        gcnt[i] <= '0;
      end
    end else begin
      part_o <= next_part;
      for (int i = 0; i < NPORT; i++) begin
        ccnt[i] <= next_ccnt[i];
        gcnt[i] <= next_gcnt[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  AST_ACT_ON_RX: // [RULE1]
    assert property ((|rx_eff) |=> act_req_o)
      else $error("receiving port did not raise activity");

  AST_ACT_JAM_QUIET: // [RULE2]
    assert property ((next_state == RAC_JAM) && !(|rx_eff) |=> !act_req_o && col_o)
      else $error("jam without reception still marked active");

  AST_ACT_IDLE: // [RULE3]
    assert property ((state == RAC_IDLE) && (next_state == RAC_IDLE) |=> !act_req_o ##1 !act_req_o || $past(|rx_eff))
      else $error("activity request high while idle");

  AST_MULTI_RX: // [RULE4]
    assert property ((pop_cnt(rx_eff) >= 4'h2) |=> col_o)
      else $error("two receiving ports did not cause collision");

  AST_RX_WHILE_TX: // [RULE5]
    assert property ((|(rx_eff & tx_en_o)) |=> col_o)
      else $error("reception on transmitting port did not cause collision");

  AST_AUI_COL: // [RULE6]
    assert property (aui_col_i && !part_o[AUI_IDX] |=> col_o)
      else $error("aui collision indication ignored");

  AST_JAM_PATTERN: // [RULE7]
    assert property ((next_state == RAC_JAM) |=> (tx_en_o == PORT_ALL) && (tx_data_o == ~$past(tx_data_o)))
      else $error("jam pattern not alternating on all ports");

  AST_PARTITION: // [RULE8]
    assert property ($rose(part_o[0]) |-> (ccnt[0] == CCNT_W'(PART_LIMIT)) && $past(col_entry))
      else $error("port partitioned without reaching collision limit");

  AST_AUI_RXCOL: // [RULE9]
    assert property (aui_col_i && !part_o[AUI_IDX] && !tx_en_o[AUI_IDX] |=> rx_col_o[AUI_IDX])
      else $error("aui receive collision not flagged");

  AST_AUI_TXCOL: // [RULE10]
    assert property (aui_col_i && !part_o[AUI_IDX] && tx_en_o[AUI_IDX] |=> tx_col_o[AUI_IDX])
      else $error("aui transmit collision not flagged");

  AST_TP_TXCOL: // [RULE11]
    assert property (rx_eff[0] && tx_en_o[0] && !one_left |=> tx_col_o[0] && !rx_col_o[0])
      else $error("twisted pair transmit collision not flagged");

endmodule : rac_top

// File: tb/rac_seg_model.sv
// Network segment model: eight twisted-pair segments, the AUI segment and the transmit ready line
`timescale 1ns/1ps
module rac_seg_model
  import rac_pkg::*;
#(
  parameter int unsigned DATA_W = DATA_W_DEF
) (
  // Clock
  input  wire logic              mclk_i,
  // Commands from the bench
  input  wire logic [NPORT-1:0]  car_i,
  input  wire logic              col_i,
  input  wire logic [DATA_W-1:0] word_i,
  input  wire logic              stall_i,
  // Segment lines toward the repeater
  output logic [NPORT-1:0]       rx_carrier_o,
  output logic [DATA_W-1:0]      rx_data_o [NPORT],
  output logic                   aui_col_o,
  output logic                   tx_ready_o
);
  logic [DATA_W-1:0] noise;

  // Idle segments show a changing pattern, so a stale word is never mistaken for data
  always @(posedge mclk_i) begin
    noise <= ~noise;
  end

  initial noise = '0;

  always_comb begin
    rx_carrier_o = car_i;
    aui_col_o    = col_i;
    tx_ready_o   = ~stall_i;
    for (int p = 0; p < NPORT; p++) begin
      rx_data_o[p] = car_i[p] ? word_i : noise;
    end
  end
endmodule : rac_seg_model

// File: tb/repeater_activity_collision_state_test.sv
// Self-checking testbench for the repeater activity and collision block
`timescale 1ns/1ps
module repeater_activity_collision_state_test;
  import rac_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  localparam int unsigned PL = 3;
  localparam int unsigned RC = 8;
  localparam int          I_ACT = 0;
  localparam int          I_COL = 1;
  localparam int          I_RDY = 2;
  localparam int          I_TXC = 3;
  localparam int          I_RXC = 12;
  localparam int          I_PRT = 21;

  logic                  mclk_i;
  logic                  sys_rst_i;
  logic [NPORT-1:0]      car;
  logic                  aui;
  logic [DATA_W_DEF-1:0] word;
  logic                  stall;
  logic [NPORT-1:0]      rx_carrier;
  logic [DATA_W_DEF-1:0] rx_data [NPORT];
  logic                  aui_col;
  logic                  tx_ready;
  logic                  rx_ready_o;
  logic [NPORT-1:0]      tx_en_o;
  logic [DATA_W_DEF-1:0] tx_data_o;
  logic                  act_req_o;
  logic                  col_o;
  logic [NPORT-1:0]      tx_col_o;
  logic [NPORT-1:0]      rx_col_o;
  logic [NPORT-1:0]      part_o;
  wire  [29:0]           mon = {part_o, rx_col_o, tx_col_o, rx_ready_o, col_o, act_req_o};
  int                    fails;
  int                    checked;

  rac_seg_model u_rac_seg_model (.mclk_i(mclk_i), .car_i(car), .col_i(aui), .word_i(word), .stall_i(stall),
    .rx_carrier_o(rx_carrier), .rx_data_o(rx_data), .aui_col_o(aui_col), .tx_ready_o(tx_ready));

  rac_top #(.PART_LIMIT(PL), .RECON_CYC(RC)) u_rac_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .rx_carrier_i(rx_carrier), .rx_data_i(rx_data), .aui_col_i(aui_col), .rx_ready_o(rx_ready_o),
    .tx_ready_i(tx_ready), .tx_en_o(tx_en_o), .tx_data_o(tx_data_o), .act_req_o(act_req_o),
    .col_o(col_o), .tx_col_o(tx_col_o), .rx_col_o(rx_col_o), .part_o(part_o));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask : step

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bounded wait on one monitored bit; running out ends the run
  task automatic wait_bit(input int i, input logic v, input int lim, input string n);
    bit ok;
    ok = 1'b0;
    for (int k = 0; k < lim && !ok; k++) begin
      step;
      ok = (mon[i] === v);
    end
    checked++;
    if (!ok) begin
      fails++;
      $display("Error %s expected %b seen %b", n, v, mon[i]);
      tally_and_finish;
    end
  endtask : wait_bit

  task automatic go_idle;
    @(posedge mclk_i) begin
      car   <= '0;
      aui   <= 1'b0;
      stall <= 1'b0;
    end
    wait_bit(I_COL, 1'b0, 6, "col_o");
    wait_bit(I_ACT, 1'b0, 8, "act_req_o");
  endtask : go_idle

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    step;
    chk("tx_en_o", 9'h000, tx_en_o);
    chk("act_req_o", 9'h000, act_req_o);
    chk("rx_ready_o", 9'h001, rx_ready_o);
    chk("part_o", 9'h000, part_o);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single;
    @(posedge mclk_i) car <= 9'h004;
    step;
    chk("act_req_o", 9'h001, act_req_o);
    chk("tx_en_o", 9'h1FB, tx_en_o);
    chk("col_o", 9'h000, col_o);
    step;
    step;
    chk("tx_data_o", 9'h001, tx_data_o);
    go_idle;
    chk("tx_en_o", 9'h000, tx_en_o);
    $display("test single done");
  endtask : t_single

  task automatic t_multi;
    logic p;
    @(posedge mclk_i) car <= 9'h030;
    step;
    chk("col_o", 9'h001, col_o);
    chk("tx_en_o", 9'h1FF, tx_en_o);
    chk("act_req_o", 9'h001, act_req_o);
    for (int k = 0; k < 3; k++) begin
      p = tx_data_o[0];
      step;
      chk("tx_data_o", {8'h00, ~p}, tx_data_o);
    end
    @(posedge mclk_i) car <= 9'h010;
    wait_bit(I_RXC + 4, 1'b1, 3, "rx_col_o");
    @(posedge mclk_i) car <= 9'h000;
    step;
    chk("act_req_o", 9'h000, act_req_o);
    go_idle;
    $display("test multi done");
  endtask : t_multi

  task automatic t_aui;
    @(posedge mclk_i) aui <= 1'b1;
    step;
    chk("col_o", 9'h001, col_o);
    chk("act_req_o", 9'h000, act_req_o);
    chk("rx_col_o", 9'h100, rx_col_o);
    go_idle;
    @(posedge mclk_i) car <= 9'h004;
    @(posedge mclk_i) aui <= 1'b1;
    wait_bit(I_TXC + 8, 1'b1, 2, "tx_col_o");
    go_idle;
    $display("test aui done");
  endtask : t_aui

  task automatic t_stall;
    @(posedge mclk_i) begin
      stall <= 1'b1;
      car   <= 9'h002;
    end
    wait_bit(I_RDY, 1'b0, 6, "rx_ready_o");
    @(posedge mclk_i) car <= 9'h000;
    step;
    chk("act_req_o", 9'h001, act_req_o);
    @(posedge mclk_i) car <= 9'h040;
    step;
    chk("col_o", 9'h001, col_o);
    chk("tx_col_o", 9'h040, tx_col_o);
    go_idle;
    $display("test stall done");
  endtask : t_stall

  task automatic t_part;
    for (int k = 0; k < PL; k++) begin
      // Ports 0 and 3 saw no earlier collision, so their counts start from zero
      @(posedge mclk_i) car <= 9'h009;
      step;
      go_idle;
    end
    wait_bit(I_PRT + 3, 1'b1, 3, "part_o");
    @(posedge mclk_i) car <= 9'h008;
    step;
    step;
    chk("act_req_o", 9'h000, act_req_o);
    wait_bit(I_PRT + 3, 1'b0, RC + 4, "part_o");
    chk("part_o", 9'h001, part_o);
    go_idle;
    $display("test partition done");
  endtask : t_part

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    fails     = 0;
    checked   = 0;
    sys_rst_i = 1'b1;
    car       = '0;
    aui       = 1'b0;
    word      = 1'b1;
    stall     = 1'b0;
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_single;
    t_multi;
    t_aui;
    t_stall;
    t_part;
    tally_and_finish;
  end
endmodule : repeater_activity_collision_state_test
